// ### suart_top.sv
// Asynchronous serial port unit: APB registers, receive control, transmit
//
// The APB register port and the register offsets are this design's own decisions.
`default_nettype none
// Function
// - While enabled, watch the line, sync to a start bit, receive a frame.
// - Shift data LSB first, then optional parity bit, then stop bit.
// - Check count of ones against even or odd parity selection.
// - Stop bit must be 1; with two stops only the first is checked.
// - All checks pass: copy byte to receive data, set receive-full.
// - Frame ends while receive-full set: set overrun, keep old data.
// - Stop bit 0: set framing error, still copy the byte.
// - Parity mismatch: set parity error, still copy the byte.
// - Any error flag set blocks reception until software clears all.
// - Receive-full with receive interrupt enable requests full interrupt.
// - Any error flag with receive interrupt enable requests error interrupt.
// - DMA read of receive data clears receive-full automatically.
// - Receiver skips frames until mp bit 1, keeps going on identifier match.
// - Multiprocessor format ignores parity enable; mp bit replaces parity.
// - Transmit-empty cleared to 0 means new data: load shift register.
// - After load set transmit-empty, start sending, request empty interrupt.
// - Frame: start 0, 7 or 8 data LSB first, optional parity or mp bit, stop 1s, idle 1s.
// - At stop bit sample transmit-empty: load next, or set done and idle.
// - Transmit done with its enable requests a transmit-done interrupt.
// - DMA write of transmit data clears transmit-empty automatically.
// - Tx disable sets empty, resets shift reg; rx disable returns the rx engine to idle, keeps rx flags and data.
module suart_top (
    // Clock, reset, enable
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_CE,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_DMA_ACC,
    // Serial line
    input  wire logic        I_RXD,
    output logic             O_TXD,
    // Service requests
    output logic             O_RX_FULL_IRQ,
    output logic             O_RX_ERR_IRQ,
    output logic             O_TX_EMPTY_IRQ,
    output logic             O_TX_DONE_IRQ
);

typedef enum logic [5:0] {
    T_IDLE  = 6'b000001,
    T_START = 6'b000010,
    T_DATA  = 6'b000100,
    T_EXTRA = 6'b001000,
    T_STOP1 = 6'b010000,
    T_STOP2 = 6'b100000
} suart_txst_e;

typedef struct packed {
    logic [4:0]  ctrl;
    logic [4:0]  mode;
    logic [15:0] baud;
    logic [7:0]  id;
    logic [15:0] div;
    logic        tick;
    logic [7:0]  tx_data_reg;
    logic [7:0]  rx_data_reg;
    logic        rxf;
    logic        txe;
    logic        txd;
    logic        ovr;
    logic        framing_err_flag;
    logic        per;
    logic        processor_select_bit;
    logic        mp_bit_tx_value;
    logic        mpm;
    suart_txst_e tst;
    logic [3:0]  tcnt;
    logic [2:0]  tbit;
    logic [7:0]  tx_shift_reg;
    logic        tmp;
    logic        tline;
    logic        tnext;
    logic [31:0] prdata;
} suart_st_s;

suart_st_s   q;
suart_st_s   n;
suart_rx_if  rif ();
logic        wr;
logic        rd;
logic        any_err;
logic        pen_eff;
logic        par_ok;
logic        keep;
logic        take;
logic        chk;
logic        ld;
logic [2:0]  lastb;
logic [31:0] rv;

function automatic logic mapped(input logic [7:0] a);
    return a == suart_pkg::A_CTRL   || a == suart_pkg::A_MODE   ||
           a == suart_pkg::A_STAT   || a == suart_pkg::A_TXDATA ||
           a == suart_pkg::A_RXDATA || a == suart_pkg::A_ID     ||
           a == suart_pkg::A_BAUD;
endfunction

suart_rx u_suart_rx (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .i_ce  (I_CE),
    .i_rxd (I_RXD),
    .rif   (rif.core)
);

assign wr      = I_PSEL && I_PENABLE && I_PWRITE;
assign rd      = I_PSEL && I_PENABLE && !I_PWRITE;
assign any_err = q.ovr || q.framing_err_flag || q.per;
assign pen_eff = q.mode[suart_pkg::MB_PEN] && !q.mode[suart_pkg::MB_MP];
assign lastb   = q.mode[suart_pkg::MB_SEVEN] ? suart_pkg::LAST7
                                            : suart_pkg::LAST8;
assign rif.en        = q.ctrl[suart_pkg::CB_RXEN] && !any_err;
assign rif.tick      = q.tick;
assign rif.seven     = q.mode[suart_pkg::MB_SEVEN];
assign rif.has_extra = pen_eff || q.mode[suart_pkg::MB_MP];
// ones count against even or odd
assign par_ok = !pen_eff ||
    ((^rif.data ^ rif.extra) == q.mode[suart_pkg::MB_ODD]);
// only payload after a matching identifier
assign keep = !q.mode[suart_pkg::MB_MP] || (!rif.extra && q.mpm);
assign take = rif.done && keep;

// Read data is captured in the setup phase so it leaves a flop
always_comb begin
    rv = 32'h0000_0000;
    if (I_PADDR == suart_pkg::A_CTRL) begin
        rv[4:0] = q.ctrl;
    end else if (I_PADDR == suart_pkg::A_MODE) begin
        rv[4:0] = q.mode;
    end else if (I_PADDR == suart_pkg::A_STAT) begin
        rv[suart_pkg::SB_RXF]  = q.rxf;
        rv[suart_pkg::SB_TXE]  = q.txe;
        rv[suart_pkg::SB_TXD]  = q.txd;
        rv[suart_pkg::SB_OVR]  = q.ovr;
        rv[suart_pkg::SB_FER]  = q.framing_err_flag;
        rv[suart_pkg::SB_PER]  = q.per;
        rv[suart_pkg::SB_MPB]  = q.processor_select_bit;
        rv[suart_pkg::SB_MP_BIT_TX_VALUE] = q.mp_bit_tx_value;
    end else if (I_PADDR == suart_pkg::A_TXDATA) begin
        rv[7:0] = q.tx_data_reg;
    end else if (I_PADDR == suart_pkg::A_RXDATA) begin
        rv[7:0] = q.rx_data_reg;
    end else if (I_PADDR == suart_pkg::A_ID) begin
        rv[7:0] = q.id;
    end else if (I_PADDR == suart_pkg::A_BAUD) begin
        rv[15:0] = q.baud;
    end
end

always_comb begin
    n   = q;
    chk = 1'b0;
    ld  = 1'b0;
    // sixteen-times bit rate tick
    // Compare with >= so a lowered baud value takes hold at once, not after a wrap
    if (q.div >= q.baud) begin
        n.div  = 16'h0000;
        n.tick = 1'b1;
    end else begin
        n.div  = q.div + 16'h0001;
        n.tick = 1'b0;
    end
    if (I_PSEL && !I_PENABLE) begin
        n.prdata = rv;
    end
    if (wr) begin
        if (I_PADDR == suart_pkg::A_CTRL) begin
            n.ctrl = I_PWDATA[4:0];
        end else if (I_PADDR == suart_pkg::A_MODE) begin
            n.mode = I_PWDATA[4:0];
        end else if (I_PADDR == suart_pkg::A_STAT) begin
            // Flags clear on a written 0, a written 1 leaves them
            n.rxf  = q.rxf && I_PWDATA[suart_pkg::SB_RXF];
            n.txe  = q.txe && I_PWDATA[suart_pkg::SB_TXE];
            n.txd  = q.txd && I_PWDATA[suart_pkg::SB_TXD];
            n.ovr  = q.ovr && I_PWDATA[suart_pkg::SB_OVR];
            n.framing_err_flag  = q.framing_err_flag && I_PWDATA[suart_pkg::SB_FER];
            n.per  = q.per && I_PWDATA[suart_pkg::SB_PER];
            n.mp_bit_tx_value = I_PWDATA[suart_pkg::SB_MP_BIT_TX_VALUE];
        end else if (I_PADDR == suart_pkg::A_TXDATA) begin
            n.tx_data_reg = I_PWDATA[7:0];
            if (I_DMA_ACC) begin
                n.txe = 1'b0;
            end
        end else if (I_PADDR == suart_pkg::A_ID) begin
            n.id = I_PWDATA[7:0];
        end else if (I_PADDR == suart_pkg::A_BAUD) begin
            n.baud = I_PWDATA[15:0];
        end
    end
    if (rd && I_DMA_ACC && I_PADDR == suart_pkg::A_RXDATA) begin
        n.rxf = 1'b0;
    end
    // Frame results come after the clears so that a set wins
    if (rif.done && q.mode[suart_pkg::MB_MP]) begin
        n.processor_select_bit = rif.extra;
        if (rif.extra) begin
            n.mpm = (rif.data == q.id);
        end
    end
    if (take) begin
        if (n.rxf) begin
            n.ovr = 1'b1;
        end else begin
            // copy and flag; errors still copy
            n.rx_data_reg = rif.data;
            n.framing_err_flag = !rif.stop_ok;
            n.per = !par_ok;
            n.rxf = rif.stop_ok && par_ok;
        end
    end
    if (!q.ctrl[suart_pkg::CB_TXEN]) begin
        n.tst   = T_IDLE;
        n.tx_shift_reg   = 8'h00;
        n.tcnt  = 4'h0;
        n.tline = 1'b1;
        n.txe   = 1'b1;
    end else begin
        case (q.tst)
            // cleared empty flag means new data
            T_IDLE: begin
                n.tline = 1'b1;
                ld      = !q.txe;
            end
            T_START, T_DATA, T_EXTRA, T_STOP1, T_STOP2: begin
                if (q.tick) begin
                    n.tcnt = q.tcnt + 4'h1;
                end
            end
            default: n.tst = T_IDLE;
        endcase
        if (q.tick && q.tcnt == suart_pkg::OVS_LAST &&
            q.tst != T_IDLE) begin
            case (q.tst)
                T_START: begin
                    n.tst   = T_DATA;
                    n.tbit  = 3'h0;
                    n.tline = q.tx_shift_reg[0];
                end
                T_DATA: begin
                    n.tx_shift_reg  = {1'b0, q.tx_shift_reg[7:1]};
                    n.tbit = q.tbit + 3'h1;
                    if (q.tbit == lastb) begin
                        if (rif.has_extra) begin
                            n.tst   = T_EXTRA;
                            n.tline = q.tmp;
                        end else begin
                            n.tst   = T_STOP1;
                            n.tline = 1'b1;
                            chk     = !q.mode[suart_pkg::MB_STOP2];
                        end
                    end else begin
                        n.tline = q.tx_shift_reg[1];
                    end
                end
                T_EXTRA: begin
                    n.tst   = T_STOP1;
                    n.tline = 1'b1;
                    chk     = !q.mode[suart_pkg::MB_STOP2];
                end
                T_STOP1: begin
                    if (q.mode[suart_pkg::MB_STOP2]) begin
                        n.tst = T_STOP2;
                        chk   = 1'b1;
                    end else begin
                        n.tst   = q.tnext ? T_START : T_IDLE;
                        n.tline = !q.tnext;
                    end
                end
                default: begin
                    n.tst   = q.tnext ? T_START : T_IDLE;
                    n.tline = !q.tnext;
                end
            endcase
        end
        // last stop bit decides: chain or finish
        if (chk) begin
            n.tnext = !q.txe;
            ld      = !q.txe;
            if (q.txe) begin
                n.txd = 1'b1;
            end
        end
        // load sets empty and starts a frame
        if (ld) begin
            n.tx_shift_reg  = q.tx_data_reg;
            n.txe  = 1'b1;
            n.txd  = 1'b0;
            n.tmp  = q.mode[suart_pkg::MB_MP] ? q.mp_bit_tx_value :
                     ((^(q.tx_data_reg & {!q.mode[suart_pkg::MB_SEVEN], 7'h7F}))
                      ^ q.mode[suart_pkg::MB_ODD]);
            n.tcnt = 4'h0;
            if (q.tst == T_IDLE) begin
                n.tst   = T_START;
                n.tline = 1'b0;
            end
        end
    end
end

always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
        q       <= '0;
        q.ctrl  <= suart_pkg::CTRL_RST;
        q.mode  <= suart_pkg::MODE_RST;
        q.baud  <= suart_pkg::BAUD_RST;
        q.id    <= suart_pkg::ID_RST;
        q.txe   <= 1'b1;
        q.tst   <= T_IDLE;
        q.tline <= 1'b1;
    end else if (I_CE) begin
        q <= n;
    end
end

assign O_PRDATA  = q.prdata;
assign O_PREADY  = 1'b1;
assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped(I_PADDR);
assign O_TXD     = q.tline;
assign O_RX_FULL_IRQ  = q.rxf && q.ctrl[suart_pkg::CB_RIE];
assign O_RX_ERR_IRQ   = any_err && q.ctrl[suart_pkg::CB_RIE];
assign O_TX_EMPTY_IRQ = q.txe && q.ctrl[suart_pkg::CB_TIE];
assign O_TX_DONE_IRQ  = q.txd && q.ctrl[suart_pkg::CB_TX_DONE_IRQ_EN];

default clocking cb @(posedge I_MCLK); endclocking
default disable iff (I_RST || !I_CE);

property p_full_set;
    take && !q.rxf && rif.stop_ok && par_ok && !wr
        |=> q.rxf && q.rx_data_reg == $past(rif.data);
endproperty
a_full_set: assert property (p_full_set) else $error("no rx copy");
property p_ovr;
    take && q.rxf && !rd && !wr |=> q.ovr && $stable(q.rx_data_reg);
endproperty
a_ovr: assert property (p_ovr) else $error("overrun wrong");
property p_fer;
    take && !n.rxf && !rif.stop_ok |=> q.framing_err_flag && !q.rxf;
endproperty
a_fer: assert property (p_fer) else $error("framing wrong");
property p_per;
    take && !n.rxf && !par_ok |=> q.per && q.rx_data_reg == $past(rif.data);
endproperty
a_per: assert property (p_per) else $error("parity wrong");
property p_block;
    any_err |-> !rif.en ##1 (!q.rxf || $past(q.rxf));
endproperty
a_block: assert property (p_block) else $error("rx not blocked");
property p_err_irq;
    any_err && q.ctrl[suart_pkg::CB_RIE] |-> O_RX_ERR_IRQ;
endproperty
a_err_irq: assert property (p_err_irq) else $error("no err irq");
property p_dma_rd;
    rd && I_DMA_ACC && I_PADDR == suart_pkg::A_RXDATA && !take
        |=> !q.rxf;
endproperty
a_dma_rd: assert property (p_dma_rd) else $error("dma rd no clr");
property p_tx_off;
    !q.ctrl[suart_pkg::CB_TXEN] |=> q.txe && q.tx_shift_reg == 8'h00 && O_TXD;
endproperty
a_tx_off: assert property (p_tx_off) else $error("tx disable");
property p_load;
    q.tst == T_IDLE && !q.txe && q.ctrl[suart_pkg::CB_TXEN]
        |=> q.txe && q.tst == T_START && !O_TXD;
endproperty
a_load: assert property (p_load) else $error("tx load");
property p_idle_mark;
    q.tst == T_IDLE |-> O_TXD;
endproperty
a_idle_mark: assert property (p_idle_mark) else $error("idle low");

c_rx_full: cover property (take ##1 q.rxf);
c_overrun: cover property (take && q.rxf);
c_tx_chain: cover property (chk && !q.txe);
c_mp_match: cover property (rif.done && rif.extra && rif.data == q.id);

endmodule
`default_nettype wire

// ### suart_pkg.sv
// Constants shared by the serial port unit files
`default_nettype none
package suart_pkg;
    // APB register offsets (byte addresses)
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_MODE   = 8'h04;
    localparam logic [7:0] A_STAT   = 8'h08;
    localparam logic [7:0] A_TXDATA = 8'h0C;
    localparam logic [7:0] A_RXDATA = 8'h10;
    localparam logic [7:0] A_ID     = 8'h14;
    localparam logic [7:0] A_BAUD   = 8'h18;
    // serial_control_reg fields
    localparam int CB_RXEN = 0;
    localparam int CB_TXEN = 1;
    localparam int CB_RIE  = 2;
    localparam int CB_TIE  = 3;
    localparam int CB_TX_DONE_IRQ_EN = 4;
    // serial_mode_reg fields
    localparam int MB_SEVEN = 0;
    localparam int MB_PEN   = 1;
    localparam int MB_ODD   = 2;
    localparam int MB_MP    = 3;
    localparam int MB_STOP2 = 4;
    // serial_status_reg fields
    localparam int SB_RXF  = 0;
    localparam int SB_TXE  = 1;
    localparam int SB_TXD  = 2;
    localparam int SB_OVR  = 3;
    localparam int SB_FER  = 4;
    localparam int SB_PER  = 5;
    localparam int SB_MPB  = 6;
    localparam int SB_MP_BIT_TX_VALUE = 7;
    // Reset values
    localparam logic [4:0]  CTRL_RST = 5'h00;
    localparam logic [4:0]  MODE_RST = 5'h00;
    localparam logic [15:0] BAUD_RST = 16'h0043;
    localparam logic [7:0]  ID_RST   = 8'h00;
    // Sixteen ticks per bit, sample in the middle
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [2:0] LAST7    = 3'h6;
    localparam logic [2:0] LAST8    = 3'h7;
endpackage
`default_nettype wire

// ### suart_rx_if.sv
// Carrier between the receive bit engine and the register side
`default_nettype none
interface suart_rx_if;
    logic       en;
    logic       tick;
    logic       seven;
    logic       has_extra;
    logic       done;
    logic [7:0] data;
    logic       extra;
    logic       stop_ok;
    modport core (input en, tick, seven, has_extra,
                  output done, data, extra, stop_ok);
    modport ctrl (output en, tick, seven, has_extra,
                  input done, data, extra, stop_ok);
endinterface
`default_nettype wire

// ### suart_rx.sv
// Receive bit engine: line sync, start detect, shift, stop sample
`default_nettype none
module suart_rx (
    // Clock, reset and enable
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Serial line
    input  wire logic i_rxd,
    // Register side
    suart_rx_if.core  rif
);

typedef enum logic [4:0] {
    R_IDLE  = 5'b00001,
    R_START = 5'b00010,
    R_DATA  = 5'b00100,
    R_EXTRA = 5'b01000,
    R_STOP  = 5'b10000
} suart_rxst_e;

typedef struct packed {
    logic        sync1;
    logic        sync2;
    suart_rxst_e st;
    logic [3:0]  cnt;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic        extra;
    logic        stop_ok;
    logic        done;
    logic [7:0]  dout;
} suart_rxq_s;

suart_rxq_s q;
suart_rxq_s n;

always_comb begin
    n       = q;
    n.done  = 1'b0;
    n.sync1 = i_rxd;
    n.sync2 = q.sync1;
    if (!rif.en) begin
        n.st = R_IDLE;
    end else if (rif.tick) begin
        case (q.st)
            R_IDLE: begin
                if (!q.sync2) begin
                    n.st  = R_START;
                    n.cnt = 4'h0;
                end
            end
            R_START: begin
                if (q.cnt == suart_pkg::OVS_MID) begin
                    n.cnt  = 4'h0;
                    n.bitn = 3'h0;
                    n.st   = q.sync2 ? R_IDLE : R_DATA;
                end else begin
                    n.cnt = q.cnt + 4'h1;
                end
            end
            R_DATA: begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == suart_pkg::OVS_LAST) begin
                    n.sh = {q.sync2, q.sh[7:1]};
                    if (q.bitn == (rif.seven ? suart_pkg::LAST7
                                             : suart_pkg::LAST8)) begin
                        n.st = rif.has_extra ? R_EXTRA : R_STOP;
                    end else begin
                        n.bitn = q.bitn + 3'h1;
                    end
                end
            end
            R_EXTRA: begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == suart_pkg::OVS_LAST) begin
                    n.extra = q.sync2;
                    n.st    = R_STOP;
                end
            end
            // only the first stop bit is sampled
            R_STOP: begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == suart_pkg::OVS_LAST) begin
                    n.stop_ok = q.sync2;
                    n.done    = 1'b1;
                    n.dout    = rif.seven ? {1'b0, q.sh[7:1]} : q.sh;
                    n.st      = R_IDLE;
                end
            end
            default: n.st = R_IDLE;
        endcase
    end
end

always_ff @(posedge i_clk) begin
    if (i_rst) begin
        q       <= '0;
        q.sync1 <= 1'b1;
        q.sync2 <= 1'b1;
        q.st    <= R_IDLE;
    end else if (i_ce) begin
        q <= n;
    end
end

assign rif.done    = q.done;
assign rif.data    = q.dout;
assign rif.extra   = q.extra;
assign rif.stop_ok = q.stop_ok;

endmodule
`default_nettype wire

// ### suart_node.sv
// Serial node on the far side of the line: sends frames, decodes frames
`default_nettype none
module suart_node #(
    parameter int BT = 16
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] rxq[$];
    logic [9:0] w;

    initial rxd = 1'b1;

    // Optional extra bit carries parity or the mp bit
    task automatic send(input logic [7:0] d, input logic hx,
                        input logic x, input logic stp);
        logic [11:0] f;
        f = hx ? {1'b1, stp, x, d, 1'b0} : {2'b11, stp, d, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            rxd <= f[i];
            repeat (BT) @(posedge clk);
        end
        // Mark state between frames
        repeat (BT) @(posedge clk);
    endtask

    // Decode data, extra bit and stop bit at mid period
    initial forever begin
        @(negedge txd);
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BT) @(posedge clk);
            w[i] = txd;
        end
        rxq.push_back(w);
    end
endmodule
`default_nettype wire

// ### tb_suart_top.sv
// Self-checking bench for the serial port unit
`default_nettype none
module tb_suart_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, psel, penable, pwrite, dma;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rdat;
    logic [31:0] prdata;
    logic        pready, pslverr, serr, rxd, txd;
    logic        rfi, rei, tx_done_irq, tdi;
    int          miscompares, num_checks;

    suart_top u_suart_top (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DMA_ACC(dma),
        .I_RXD(rxd), .O_TXD(txd), .O_RX_FULL_IRQ(rfi),
        .O_RX_ERR_IRQ(rei), .O_TX_EMPTY_IRQ(tdi), .O_TX_DONE_IRQ(tx_done_irq));
    suart_node u_suart_node (.clk(clk), .txd(txd), .rxd(rxd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic dm);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= d; dma <= dm;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0; dma <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic t_reset();
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[5:3], rdat[1:0]}, 32'h0000_0002);
        apb(0, suart_pkg::A_BAUD, 0, 0);
        chk(rdat, 32'h0000_0043);
        apb(0, suart_pkg::A_CTRL, 0, 0);
        chk(rdat, 32'h0000_0000);
        apb(0, 8'h1C, 0, 0);
        chk(serr, 32'h0000_0001);
        chk(rdat, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_rx_ok();
        u_suart_node.send(8'hA5, 0, 0, 1);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk(rdat[5:3], 32'h0);
        chk({rdat[0], rfi}, 32'h3);
        apb(0, suart_pkg::A_RXDATA, 0, 0);
        chk(rdat, 32'h0000_00A5);
        apb(1, suart_pkg::A_STAT, 32'h0000_007E, 0);
        // The flag clears at the access edge: look one edge later
        @(posedge clk);
        chk(rfi, 0);
        $display("test rx ok done");
    endtask

    task automatic t_overrun();
        u_suart_node.send(8'h3C, 0, 0, 1);
        u_suart_node.send(8'hC3, 0, 0, 1);
        u_suart_node.send(8'h11, 0, 0, 1);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[3], rei}, 32'h3);
        apb(0, suart_pkg::A_RXDATA, 0, 0);
        chk(rdat, 32'h0000_003C);
        apb(1, suart_pkg::A_STAT, 32'h0000_0006, 0);
        u_suart_node.send(8'h5A, 0, 0, 1);
        apb(0, suart_pkg::A_RXDATA, 0, 0);
        chk(rdat, 32'h0000_005A);
        apb(1, suart_pkg::A_STAT, 32'h0000_0006, 0);
        $display("test overrun done");
    endtask

    task automatic t_errors();
        u_suart_node.send(8'h77, 0, 0, 0);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[4], rdat[0], rei}, 32'h5);
        apb(0, suart_pkg::A_RXDATA, 0, 0);
        chk(rdat, 32'h0000_0077);
        apb(1, suart_pkg::A_STAT, 32'h0000_0006, 0);
        apb(1, suart_pkg::A_MODE, 32'h0000_0012, 0);
        u_suart_node.send(8'h01, 1, 0, 1);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[5], rdat[0]}, 32'h2);
        apb(0, suart_pkg::A_RXDATA, 0, 0);
        chk(rdat, 32'h0000_0001);
        apb(1, suart_pkg::A_STAT, 32'h0000_0006, 0);
        apb(1, suart_pkg::A_MODE, 32'h0000_0016, 0);
        u_suart_node.send(8'h07, 1, 0, 1);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk(rdat[5:0], 32'h3);
        $display("test errors done");
    endtask

    task automatic t_dma();
        apb(1, suart_pkg::A_MODE, 32'h0000_0000, 0);
        apb(1, suart_pkg::A_STAT, 32'h0000_0006, 0);
        apb(1, suart_pkg::A_CTRL, 32'h0000_001B, 0);
        u_suart_node.send(8'h81, 0, 0, 1);
        chk(rfi, 0);
        apb(0, suart_pkg::A_RXDATA, 0, 1);
        chk(rdat, 32'h0000_0081);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk(rdat[0], 0);
        apb(1, suart_pkg::A_CTRL, 32'h0000_001F, 0);
        $display("test dma done");
    endtask

    task automatic t_mp();
        apb(1, suart_pkg::A_ID, 32'h0000_0012, 0);
        apb(1, suart_pkg::A_MODE, 32'h0000_000A, 0);
        u_suart_node.send(8'h55, 1, 0, 1);
        u_suart_node.send(8'h34, 1, 1, 1);
        u_suart_node.send(8'h66, 1, 0, 1);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk(rdat[5:0], 32'h2);
        u_suart_node.send(8'h12, 1, 1, 1);
        // Odd count of ones with a 0 extra bit: a parity check would refuse it
        u_suart_node.send(8'h98, 1, 0, 1);
        apb(0, suart_pkg::A_RXDATA, 0, 0);
        chk(rdat, 32'h0000_0098);
        $display("test mp rx done");
    endtask

    task automatic t_tx();
        apb(1, suart_pkg::A_MODE, 32'h0000_0008, 0);
        apb(1, suart_pkg::A_TXDATA, 32'h0000_004E, 0);
        // Mp bit set in the same write that clears tx empty
        apb(1, suart_pkg::A_STAT, 32'h0000_00BD, 0);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[1], tdi}, 32'h3);
        apb(1, suart_pkg::A_TXDATA, 32'h0000_00B1, 1);
        for (int i = 0; i < 800 && u_suart_node.rxq.size() < 2; i++)
            @(posedge clk);
        chk(u_suart_node.rxq.size(), 2);
        chk(u_suart_node.rxq[0], 32'h34E);
        chk(u_suart_node.rxq[1], 32'h3B1);
        repeat (20) @(posedge clk);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[2], tx_done_irq, txd}, 32'h7);
        // Start a frame of zeros, cut it by a disable, then try a new load
        apb(1, suart_pkg::A_TXDATA, 32'h0000_0000, 0);
        apb(1, suart_pkg::A_STAT, 32'h0000_003D, 0);
        apb(1, suart_pkg::A_CTRL, 32'h0000_001D, 0);
        apb(1, suart_pkg::A_STAT, 32'h0000_003D, 0);
        apb(0, suart_pkg::A_STAT, 0, 0);
        chk({rdat[1], txd}, 32'h3);
        $display("test tx done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        dma = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        miscompares = 0; num_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        // Tick every cycle keeps each bit at sixteen clocks
        apb(1, suart_pkg::A_BAUD, 32'h0000_0000, 0);
        apb(1, suart_pkg::A_CTRL, 32'h0000_001F, 0);
        t_rx_ok();
        t_overrun();
        t_errors();
        t_dma();
        t_mp();
        t_tx();
        conclude();
    end

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
